//--- hw/sad_divider_regs.sv
// Synthesizer A divider configuration register bank with AXI4-Lite access
`timescale 1ns/1ns
module sad_divider_regs (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	// AXI4-Lite write address
	input  wire logic [sad_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [sad_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// Sync event pin from outside
	input  wire logic                       sync_event_pin,
	// Configuration to the synthesizer
	output logic                            ref_doubler_enable,
	output logic [3:0]                      pump_gain_code,
	output logic [12:0]                     pump_current_ua,
	output logic [11:0]                     integer_feedback_divider,
	output logic [11:0]                     divide_ratio,
	output logic [21:0]                     fraction_numerator,
	output logic [21:0]                     fraction_denominator,
	output logic [21:0]                     effective_numerator,
	output logic [1:0]                      dither_select,
	output logic                            dither_enable,
	output logic [1:0]                      modulator_order,
	output logic                            fractional_active,
	output logic                            resync_enable,
	output logic                            resync_pulse
);
	import sad_pkg::*;

	// ------------------------------------------------------------
	// Storage and bus state
	// ------------------------------------------------------------
	logic [7:0]        regs_reg [NREG];
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rdata_reg;

	// Combinational bus decode
	logic              aw_take;
	logic              w_take;
	logic              aw_ok;
	logic              w_ok;
	logic              wr_fire;
	logic              ar_take;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_hit;
	logic [6:0]        wr_slot;
	logic [1:0]        wr_code;
	logic              rd_hit;
	logic [6:0]        rd_slot;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------

	// Index match covers only aligned words of the mapped range
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		return (a[1:0] == 2'h0) &&
		       (a[ADDR_W-1:2] >= 10'(IDX_RESYNC_CTRL)) &&
		       (a[ADDR_W-1:2] <= 10'(IDX_MOD_CTRL));
	endfunction

	function automatic logic [6:0] addr_slot(input logic [ADDR_W-1:0] a);
		return 7'(a[8:2] - IDX_RESYNC_CTRL);
	endfunction

	// ------------------------------------------------------------
	// Write channel handshakes
	// ------------------------------------------------------------

	// Each channel is taken once and held until the pair is complete
	assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
	assign aw_take       = s_axi_awvalid & s_axi_awready;
	assign w_take        = s_axi_wvalid & s_axi_wready;
	assign aw_ok         = aw_held_reg | aw_take;
	assign w_ok          = w_held_reg | w_take;
	assign wr_fire       = aw_ok & w_ok & ~bvalid_reg;
	assign wr_addr       = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
	assign wr_data       = w_held_reg ? w_data_reg : s_axi_wdata;
	assign wr_strb       = w_held_reg ? w_strb_reg : s_axi_wstrb;
	assign wr_hit        = addr_hit(wr_addr);
	assign wr_slot       = addr_slot(wr_addr);
	assign wr_code       = wr_hit ? RESP_OKAY : RESP_SLVERR;

	// Hold a channel that arrived before its partner
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end else begin
				if (aw_take) begin
					aw_held_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr;
				end
				if (w_take) begin
					w_held_reg <= 1'b1;
					w_data_reg <= s_axi_wdata;
					w_strb_reg <= s_axi_wstrb;
				end
			end
		end
	end

	// Response follows the completed pair; unmapped words answer SLVERR
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_code;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// ------------------------------------------------------------
	// Register array
	// ------------------------------------------------------------

	// One flop byte per register; only lane 0 carries data, and
	// reserved bits are masked so they always read back as zero
	for (genvar i = 0; i < NREG; i++) begin : g_reg
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				regs_reg[i] <= REG_RST[i*8 +: 8];
			end else if (wr_fire && wr_hit && wr_strb[0] && (wr_slot == 7'(i))) begin
				regs_reg[i] <= wr_data[7:0] & REG_MSK[i*8 +: 8];
			end
		end
	end

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------

	// One read at a time; address is refused while data waits
	assign s_axi_arready = ~rvalid_reg;
	assign ar_take       = s_axi_arvalid & s_axi_arready;
	assign rd_hit        = addr_hit(s_axi_araddr);
	assign rd_slot       = addr_slot(s_axi_araddr);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end else if (ar_take) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_reg  <= rd_hit ? {24'h000000, regs_reg[rd_slot[3:0]]} : 32'h00000000;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;

	// ------------------------------------------------------------
	// Field assembly
	// ------------------------------------------------------------

	// Fields straight from the register flops
	assign resync_enable            = regs_reg[S_RESYNC][F_RESYNC_EN];
	assign ref_doubler_enable       = regs_reg[S_DBL][F_DOUBLER];
	assign pump_gain_code           = regs_reg[S_DBL][F_PUMP_HI:0];
	assign integer_feedback_divider = {regs_reg[S_NHI][3:0], regs_reg[S_NLO]};
	assign fraction_numerator       = {regs_reg[S_UT][5:0], regs_reg[S_UM], regs_reg[S_UB]};
	assign fraction_denominator     = {regs_reg[S_DT][5:0], regs_reg[S_DM], regs_reg[S_DB]};
	assign dither_select            = regs_reg[S_MOD][F_DITH_HI:F_DITH_LO];
	assign modulator_order          = regs_reg[S_MOD][F_ORD_HI:0];

	// ------------------------------------------------------------
	// Decode and sync event
	// ------------------------------------------------------------

	// Decoded values lag the register write by one clock
	sad_field_decode u_decode (
		.clk                      (clk),
		.sys_rst                  (sys_rst),
		.pump_gain_code           (pump_gain_code),
		.integer_feedback_divider (integer_feedback_divider),
		.fraction_numerator       (fraction_numerator),
		.dither_select            (dither_select),
		.modulator_order          (modulator_order),
		.pump_current_ua          (pump_current_ua),
		.divide_ratio             (divide_ratio),
		.effective_numerator      (effective_numerator),
		.dither_enable            (dither_enable),
		.fractional_active        (fractional_active)
	);

	// Pin is asynchronous, so it is resynchronised inside
	sad_sync_event u_sync (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.sync_event_pin (sync_event_pin),
		.resync_enable  (resync_enable),
		.resync_pulse   (resync_pulse)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Write of a given slot with lane 0 enabled
	sequence wr_slot_s(int unsigned s);
		wr_fire && wr_hit && wr_strb[0] && (wr_slot == 7'(s));
	endsequence

	// Complete pair taken, then response valid on the next clock with the pair's code
	sequence wr_resp_s;
		##1 s_axi_bvalid [*1] ##0 (s_axi_bresp == $past(wr_code));
	endsequence

	write_resp_a: assert property (wr_fire |-> wr_resp_s)
		else $error("write response missing after pair");

	read_answer_a: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not presented after address");

	doubler_write_a: assert property (wr_slot_s(S_DBL) |=> ref_doubler_enable == $past(wr_data[F_DOUBLER]))
		else $error("doubler enable not taken from write");

	pump_decode_a: assert property (pump_gain_code == PUMP_HIGH_CODE |=> pump_current_ua == PUMP_HIGH_UA)
		else $error("top pump code not decoded to high current");

	pump_step_a: assert property (
		pump_gain_code <= PUMP_MAX_STEP |=> pump_current_ua == 13'($past(pump_gain_code) * PUMP_STEP_UA))
		else $error("pump step current wrong");

	int_assemble_a: assert property (
		wr_slot_s(S_NLO) |=> integer_feedback_divider[7:0] == $past(wr_data[7:0]))
		else $error("integer divider low byte wrong");

	int_high_a: assert property (wr_slot_s(S_NHI) |=> integer_feedback_divider[11:8] == $past(wr_data[3:0]))
		else $error("integer divider high nibble wrong");

	ratio_unity_a: assert property (integer_feedback_divider <= NDIV_UNITY |=> divide_ratio == NDIV_UNITY)
		else $error("small divider code not treated as one");

	ratio_follow_a: assert property (
		integer_feedback_divider > NDIV_UNITY |=> divide_ratio == $past(integer_feedback_divider))
		else $error("divide ratio differs from code");

	reset_default_a: assert property (disable iff (1'b0)
		sys_rst |-> integer_feedback_divider == NDIV_RST && ref_doubler_enable &&
		pump_gain_code == PUMP_HIGH_CODE &&
		fraction_numerator == 22'h000000 && fraction_denominator == 22'h000000 &&
		dither_select == DITHER_OFF && modulator_order == ORDER_INTEGER)
		else $error("reset defaults wrong");

	numer_top_a: assert property (wr_slot_s(S_UT) |=> fraction_numerator[21:16] == $past(wr_data[5:0]))
		else $error("numerator top bits wrong");

	numer_mid_a: assert property (wr_slot_s(S_UM) |=> fraction_numerator[15:8] == $past(wr_data[7:0]))
		else $error("numerator middle byte wrong");

	numer_low_a: assert property (wr_slot_s(S_UB) |=> fraction_numerator[7:0] == $past(wr_data[7:0]))
		else $error("numerator bottom byte wrong");

	denom_top_a: assert property (wr_slot_s(S_DT) |=> fraction_denominator[21:16] == $past(wr_data[5:0]))
		else $error("denominator top bits wrong");

	denom_mid_a: assert property (wr_slot_s(S_DM) |=> fraction_denominator[15:8] == $past(wr_data[7:0]))
		else $error("denominator middle byte wrong");

	denom_low_a: assert property (wr_slot_s(S_DB) |=> fraction_denominator[7:0] == $past(wr_data[7:0]))
		else $error("denominator bottom byte wrong");

	dither_decode_a: assert property (##1 dither_enable == ($past(dither_select) != DITHER_OFF))
		else $error("dither enable decode wrong");

	dither_write_a: assert property (wr_slot_s(S_MOD) |=> dither_select == $past(wr_data[F_DITH_HI:F_DITH_LO]))
		else $error("dither field not taken from write");

	order_integer_a: assert property (
		modulator_order == ORDER_INTEGER |=> !fractional_active && effective_numerator == 22'h000000)
		else $error("integer order still uses fraction");

	order_write_a: assert property (wr_slot_s(S_MOD) |=> modulator_order == $past(wr_data[F_ORD_HI:0]))
		else $error("order field not taken from write");

	fraction_used_a: assert property (
		modulator_order != ORDER_INTEGER |=> fractional_active && effective_numerator == $past(fraction_numerator))
		else $error("fraction not applied in mash order");

	resync_gate_a: assert property (resync_pulse |-> $past(resync_enable))
		else $error("resync pulse while disabled");
endmodule // sad_divider_regs

//--- hw/sad_field_decode.sv
// Registered decode of pump gain, divide ratio and modulator fields
`timescale 1ns/1ns
module sad_field_decode (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  pump_gain_code,
	input  wire logic [11:0] integer_feedback_divider,
	input  wire logic [21:0] fraction_numerator,
	input  wire logic [1:0]  dither_select,
	input  wire logic [1:0]  modulator_order,
	output logic      [12:0] pump_current_ua,
	output logic      [11:0] divide_ratio,
	output logic      [21:0] effective_numerator,
	output logic             dither_enable,
	output logic             fractional_active
);
	import sad_pkg::*;

	logic [12:0] pump_next;
	logic        frac_next;

	// Codes above the high code 8 are undefined and give no current
	always_comb begin
		pump_next = 13'h0000;
		if (pump_gain_code == PUMP_HIGH_CODE) begin
			pump_next = PUMP_HIGH_UA;
		end else if (pump_gain_code <= PUMP_MAX_STEP) begin
			pump_next = 13'({9'h000, pump_gain_code} * PUMP_STEP_UA);
		end
		frac_next = (modulator_order != ORDER_INTEGER);
	end

	// Decoded values held in flops for the analog side
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pump_current_ua     <= PUMP_RST_UA;
			divide_ratio        <= NDIV_RST;
			effective_numerator <= 22'h000000;
			dither_enable       <= 1'b0;
			fractional_active   <= 1'b0;
		end else begin
			pump_current_ua     <= pump_next;
			divide_ratio        <= (integer_feedback_divider <= NDIV_UNITY) ?
			                       NDIV_UNITY : integer_feedback_divider;
			effective_numerator <= frac_next ? fraction_numerator : 22'h000000;
			dither_enable       <= (dither_select != DITHER_OFF);
			fractional_active   <= frac_next;
		end
	end
endmodule // sad_field_decode

//--- hw/sad_pkg.sv
// Constants shared by the synthesizer A divider configuration block
package sad_pkg;
	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [6:0] IDX_RESYNC_CTRL = 7'h38;
	localparam logic [6:0] IDX_DOUBLER_PUMP = 7'h39;
	localparam logic [6:0] IDX_INT_DIV_HIGH = 7'h3a;
	localparam logic [6:0] IDX_INT_DIV_LOW  = 7'h3b;
	localparam logic [6:0] IDX_NUMER_TOP    = 7'h3c;
	localparam logic [6:0] IDX_NUMER_MID    = 7'h3d;
	localparam logic [6:0] IDX_NUMER_BOTTOM = 7'h3e;
	localparam logic [6:0] IDX_DENOM_TOP    = 7'h3f;
	localparam logic [6:0] IDX_DENOM_MID    = 7'h40;
	localparam logic [6:0] IDX_DENOM_BOTTOM = 7'h41;
	localparam logic [6:0] IDX_MOD_CTRL     = 7'h42;
	localparam int unsigned NREG = 11;

	// Slot numbers in the register array (index minus first index)
	localparam int unsigned S_RESYNC = 0;
	localparam int unsigned S_DBL    = 1;
	localparam int unsigned S_NHI    = 2;
	localparam int unsigned S_NLO    = 3;
	localparam int unsigned S_UT     = 4;
	localparam int unsigned S_UM     = 5;
	localparam int unsigned S_UB     = 6;
	localparam int unsigned S_DT     = 7;
	localparam int unsigned S_DM     = 8;
	localparam int unsigned S_DB     = 9;
	localparam int unsigned S_MOD    = 10;

	// Reset values and writable-bit masks, slot 0 in the low byte
	localparam logic [NREG*8-1:0] REG_RST = 88'h0c_00_00_00_00_00_00_66_00_18_02;
	localparam logic [NREG*8-1:0] REG_MSK = 88'h0f_ff_ff_3f_ff_ff_3f_ff_0f_3f_02;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int unsigned F_RESYNC_EN = 1;
	localparam int unsigned F_DOUBLER   = 4;
	localparam int unsigned F_PUMP_HI   = 3;
	localparam int unsigned F_DITH_HI   = 3;
	localparam int unsigned F_DITH_LO   = 2;
	localparam int unsigned F_ORD_HI    = 1;

	// ------------------------------------------------------------
	// Field codes and decoded values
	// ------------------------------------------------------------
	localparam logic [3:0]  PUMP_MAX_STEP  = 4'h7;
	localparam logic [3:0]  PUMP_HIGH_CODE = 4'h8;
	localparam logic [12:0] PUMP_STEP_UA   = 13'h0190;
	localparam logic [12:0] PUMP_HIGH_UA   = 13'h1900;
	localparam logic [12:0] PUMP_RST_UA    = 13'h1900;
	localparam logic [11:0] NDIV_RST       = 12'h066;
	localparam logic [11:0] NDIV_UNITY     = 12'h001;
	localparam logic [1:0]  DITHER_OFF     = 2'h3;
	localparam logic [1:0]  ORDER_INTEGER  = 2'h0;
endpackage

//--- hw/sad_sync_event.sv
// Synchroniser and gated edge detector for the resync event pin
`timescale 1ns/1ns
module sad_sync_event (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic sync_event_pin,
	input  wire logic resync_enable,
	output logic      resync_pulse
);
	import sad_pkg::*;

	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// Two flops before any logic looks at the pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= sync_event_pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// Rising edge only counts while the enable is set
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			resync_pulse <= 1'b0;
		end else begin
			resync_pulse <= sync_reg & ~last_reg & resync_enable;
		end
	end
endmodule // sad_sync_event

//--- test/sad_divider_regs_tb.sv
// Self-checking bench for the synthesizer A divider configuration bank
`timescale 1ns/1ns
module sad_divider_regs_tb;
	import sad_pkg::*;
	// ------------------------------------------------------------
	// Stimulus, observed outputs and bench state
	// ------------------------------------------------------------
	logic        clk            = 1'b0;
	logic        sys_rst        = 1'b0;
	logic [11:0] s_axi_awaddr   = 12'h000;
	logic        s_axi_awvalid  = 1'b0;
	logic [31:0] s_axi_wdata    = 32'h0;
	logic [3:0]  s_axi_wstrb    = 4'h0;
	logic        s_axi_wvalid   = 1'b0;
	logic        s_axi_bready   = 1'b0;
	logic [11:0] s_axi_araddr   = 12'h000;
	logic        s_axi_arvalid  = 1'b0;
	logic        s_axi_rready   = 1'b0;
	logic        sync_event_pin = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        ref_doubler_enable, dither_enable, fractional_active, resync_enable, resync_pulse;
	logic [3:0]  pump_gain_code;
	logic [12:0] pump_current_ua;
	logic [11:0] integer_feedback_divider, divide_ratio;
	logic [21:0] fraction_numerator, fraction_denominator, effective_numerator;
	logic [1:0]  dither_select, modulator_order;
	logic [7:0]  m [0:10];
	int          n_mismatch = 0;
	int          n_tests    = 0;
	int          cyc        = 0;

	sad_divider_regs uut (
		.clk(clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sync_event_pin(sync_event_pin),
		.ref_doubler_enable(ref_doubler_enable), .pump_gain_code(pump_gain_code),
		.pump_current_ua(pump_current_ua), .integer_feedback_divider(integer_feedback_divider),
		.divide_ratio(divide_ratio), .fraction_numerator(fraction_numerator),
		.fraction_denominator(fraction_denominator), .effective_numerator(effective_numerator),
		.dither_select(dither_select), .dither_enable(dither_enable), .modulator_order(modulator_order),
		.fractional_active(fractional_active), .resync_enable(resync_enable), .resync_pulse(resync_pulse)
	);

	// 50 MHz clock
	always #10 clk = ~clk;

	// Hang guard; the whole run needs about six hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done;
		end
	end

	// ------------------------------------------------------------
	// Reference model and comparison
	// ------------------------------------------------------------
	// Writable bits per slot; reserved bits must read back as zero
	function automatic logic [7:0] msk(input int s);
		case (s)
			0: return 8'h02;
			1, 4, 7: return 8'h3f;
			2, 10: return 8'h0f;
			default: return 8'hff;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Reset held for two edges, bus idle, model back to defaults
	task automatic rst_seq;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		m = '{8'h02, 8'h18, 8'h00, 8'h66, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0c};
		@(posedge clk);
	endtask

	// ------------------------------------------------------------
	// AXI4-Lite master; handshakes judged on the settled pre-edge values
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
		logic       ta, tw, tb;
		logic [1:0] r;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			r  = s_axi_bresp;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge clk);
		chk({30'h0, r}, {30'h0, er}, "bresp");
	endtask

	task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [7:0] ed);
		logic        ta, tr;
		logic [1:0]  r;
		logic [31:0] d;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			r  = s_axi_rresp;
			d  = s_axi_rdata;
			@(posedge clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge clk);
		chk({30'h0, r}, {30'h0, er}, "rresp");
		chk(d, {24'h0, ed}, "rdata");
	endtask

	task automatic wr_reg(input int s, input logic [7:0] d);
		wr(12'h0e0 + 12'(4 * s), d, 4'h1, RESP_OKAY);
		m[s] = d & msk(s);
	endtask

	// Decoded outputs lag the fields by one clock; wr leaves two edges
	task automatic outs;
		logic [11:0] nd;
		logic [21:0] nu;
		logic [3:0]  pc;
		logic [12:0] ua;
		nd = {m[2][3:0], m[3]};
		nu = {m[4][5:0], m[5], m[6]};
		pc = m[1][3:0];
		ua = (pc >= 4'h1 && pc <= 4'h7) ? 13'(pc) * 13'h190 : (pc == 4'h8) ? 13'h1900 : 13'h0;
		@(negedge clk);
		chk(32'(ref_doubler_enable), 32'(m[1][4]), "doubler");
		chk(32'(pump_gain_code), 32'(pc), "pump code");
		chk(32'(pump_current_ua), 32'(ua), "pump current");
		chk(32'(integer_feedback_divider), 32'(nd), "int divider");
		chk(32'(divide_ratio), 32'((nd < 12'h002) ? 12'h001 : nd), "ratio");
		chk(32'(fraction_numerator), 32'(nu), "numerator");
		chk(32'(fraction_denominator), 32'({m[7][5:0], m[8], m[9]}), "denominator");
		chk(32'(dither_select), 32'(m[10][3:2]), "dither");
		chk(32'(dither_enable), 32'(m[10][3:2] != 2'h3), "dither on");
		chk(32'(modulator_order), 32'(m[10][1:0]), "order");
		chk(32'(fractional_active), 32'(m[10][1:0] != 2'h0), "frac on");
		chk(32'(effective_numerator), 32'((m[10][1:0] != 2'h0) ? nu : 22'h0), "eff num");
		chk(32'(resync_enable), 32'(m[0][1]), "resync en");
		@(posedge clk);
	endtask

	task automatic check_all;
		for (int s = 0; s < 11; s++)
			rd(12'h0e0 + 12'(4 * s), RESP_OKAY, m[s]);
		outs;
	endtask

	// A pin rise gives one pulse three edges later, only while enabled
	task automatic sync_chk;
		int cnt;
		int pos;
		cnt = 0;
		pos = -1;
		sync_event_pin <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			@(negedge clk);
			if (resync_pulse === 1'b1) begin
				cnt++;
				if (pos < 0) pos = i;
			end
			@(posedge clk);
		end
		sync_event_pin <= 1'b0;
		repeat (4) @(posedge clk);
		chk(32'(cnt), m[0][1] ? 32'h1 : 32'h0, "pulse count");
		if (m[0][1]) chk(32'(pos), 32'h3, "pulse place");
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		logic [11:0] dv [0:3];
		dv = '{12'h000, 12'h001, 12'h002, 12'hfff};
		void'($urandom(32'he58e));
		rst_seq;
		check_all;
		$display("test reset values done");
		repeat (4) begin
			for (int s = 0; s < 11; s++)
				wr_reg(s, 8'($urandom));
			check_all;
		end
		$display("test random fields done");
		for (int c = 0; c < 16; c++) begin
			wr_reg(1, {4'($urandom), 4'(c)});
			outs;
		end
		$display("test pump codes done");
		foreach (dv[i]) begin
			wr_reg(2, {4'($urandom), dv[i][11:8]});
			wr_reg(3, dv[i][7:0]);
			outs;
		end
		$display("test divider bounds done");
		wr_reg(5, 8'h5a);
		for (int c = 0; c < 16; c++) begin
			wr_reg(10, {4'($urandom), 4'(c)});
			outs;
		end
		$display("test modulator codes done");
		wr(12'h0ec, 8'ha5, 4'h0, RESP_OKAY);
		wr(12'h0dc, 8'h5a, 4'h1, RESP_SLVERR);
		wr(12'h10c, 8'h5a, 4'h1, RESP_SLVERR);
		wr(12'h0e5, 8'h5a, 4'h1, RESP_SLVERR);
		rd(12'h0dc, RESP_SLVERR, 8'h00);
		rd(12'h10c, RESP_SLVERR, 8'h00);
		check_all;
		$display("test refused access done");
		wr_reg(0, 8'hff);
		sync_chk;
		wr_reg(0, 8'h00);
		sync_chk;
		$display("test resync gating done");
		rst_seq;
		check_all;
		$display("test second reset done");
		test_done;
	end
endmodule // sad_divider_regs_tb
